// [logic/hbl_pkg.sv]
// Constants, register map and carrier types of the heater break block.
// Assumes a 200 MHz clock and an APB master with 32-bit data.
package hbl_pkg;

    localparam int LOOPS = 4;

    // Timing, 200 MHz clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS         = 1000000000;
    localparam int TICK_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
    localparam int DETECT_MS     = 200;
    localparam int BOOT_HOLD_MS  = 4000;

    // Current in units of 0.1 A
    localparam logic [9:0] THR_OFF  = 10'h000;
    localparam logic [9:0] THR_FORCE = 10'h1f4;

    // Register indices as printed, byte address is four times the index
    localparam logic [7:0] IDX_CTRL12 = 8'h02;
    localparam logic [7:0] IDX_CTRL34 = 8'h0c;
    localparam logic [7:0] ADDR_CTRL12 = 8'h08;
    localparam logic [7:0] ADDR_CTRL34 = 8'h30;
    localparam logic [7:0] ADDR_THR0   = 8'h40;
    localparam logic [7:0] ADDR_MON0   = 8'h50;
    localparam logic [7:0] ADDR_METHOD = 8'h60;
    localparam logic [7:0] ADDR_STATUS = 8'h64;

    // Control word layout
    localparam logic [15:0] CTRL_MASK = 16'hf05f;
    localparam int BIT_SAVE_A  = 15;
    localparam int BIT_SAVE_B  = 14;
    localparam int BIT_PID_A   = 13;
    localparam int BIT_PID_B   = 12;
    localparam int BIT_STOP_A  = 6;
    localparam int BIT_STOP_B  = 4;
    localparam int BIT_ATSTP_A = 3;
    localparam int BIT_ATSTR_A = 2;
    localparam int BIT_ATSTP_B = 1;
    localparam int BIT_ATSTR_B = 0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    typedef enum logic [1:0]
    {
        METH_TIME_PROP,
        METH_POSITION,
        METH_CYCLE
    } hbl_method_t;

    typedef struct packed
    {
        logic [LOOPS-1:0] ctrl_out;
        logic [LOOPS-1:0] alarm;
        logic [LOOPS-1:0] at_run;
        logic [LOOPS-1:0] save_req;
        logic [LOOPS-1:0] pid_chg_req;
    } hbl_loop_out_t;

    typedef struct packed
    {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } hbl_apb_rsp_t;

endpackage

// [logic/hbl_top.sv]
// Heater break alarm and run/stop control for four regulation loops.
// Assumes synchronous inputs, one 200 MHz clock and an APB master.
`timescale 1ns/1ps
`default_nettype none

module hbl_top
    import hbl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output var  hbl_apb_rsp_t          apb_rsp_o,
    // Loop side
    input  wire logic [LOOPS-1:0]      ctrl_demand_i,
    input  wire logic [LOOPS-1:0][9:0] current_sense_transformer_i,
    output var  hbl_loop_out_t         loop_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        logic [15:0]            ctrl12;
        logic [15:0]            ctrl34;
        logic [LOOPS-1:0][9:0]  thr;
        logic [LOOPS-1:0][1:0]  method;
        logic [LOOPS-1:0][9:0]  mon;
        logic [LOOPS-1:0][7:0]  on_ms;
        logic [LOOPS-1:0]       heater_break_alarm;
        logic [LOOPS-1:0]       at_run;
        logic [17:0]            tick_cnt;
        logic                   tick;
        logic [11:0]            boot_ms;
        logic                   boot_done;
        hbl_loop_out_t          out;
        hbl_apb_rsp_t           rsp;
    } hbl_state_t;

    hbl_state_t state_reg;
    hbl_state_t state_next;

    logic [LOOPS-1:0] stop_bit;
    logic [LOOPS-1:0] at_start_bit;
    logic [LOOPS-1:0] at_stop_bit;
    logic [LOOPS-1:0] save_bit;
    logic [LOOPS-1:0] pid_bit;
    logic             wr_en;
    logic             rd_en;
    logic             hit;
    logic [31:0]      rd_data;
    logic [15:0]      wdata16;

    // ****************************************************************
    // Control word fields
    // ****************************************************************
    always_comb
    begin
        stop_bit = {state_reg.ctrl34[BIT_STOP_B],
                    state_reg.ctrl34[BIT_STOP_A],
                    state_reg.ctrl12[BIT_STOP_B],
                    state_reg.ctrl12[BIT_STOP_A]};
        at_start_bit = {state_reg.ctrl34[BIT_ATSTR_B],
                        state_reg.ctrl34[BIT_ATSTR_A],
                        state_reg.ctrl12[BIT_ATSTR_B],
                        state_reg.ctrl12[BIT_ATSTR_A]};
        at_stop_bit = {state_reg.ctrl34[BIT_ATSTP_B],
                       state_reg.ctrl34[BIT_ATSTP_A],
                       state_reg.ctrl12[BIT_ATSTP_B],
                       state_reg.ctrl12[BIT_ATSTP_A]};
        save_bit = {state_reg.ctrl34[BIT_SAVE_B],
                    state_reg.ctrl34[BIT_SAVE_A],
                    state_reg.ctrl12[BIT_SAVE_B],
                    state_reg.ctrl12[BIT_SAVE_A]};
        pid_bit = {state_reg.ctrl34[BIT_PID_B],
                   state_reg.ctrl34[BIT_PID_A],
                   state_reg.ctrl12[BIT_PID_B],
                   state_reg.ctrl12[BIT_PID_A]};
    end

    // ****************************************************************
    // APB decode and read mux
    // ****************************************************************
    // One wait state: pready rises in the second access cycle
    assign wr_en   = psel_i && penable_i && !state_reg.rsp.pready && pwrite_i;
    assign rd_en   = psel_i && penable_i && !state_reg.rsp.pready && !pwrite_i;
    assign wdata16 = pwdata_i[15:0];

    always_comb
    begin
        hit     = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr_i)
            ADDR_CTRL12: rd_data = {16'h0000, state_reg.ctrl12};
            ADDR_CTRL34: rd_data = {16'h0000, state_reg.ctrl34};
            ADDR_THR0:      rd_data = {22'h000000, state_reg.thr[0]};
            ADDR_THR0 + 8'h04: rd_data = {22'h000000, state_reg.thr[1]};
            ADDR_THR0 + 8'h08: rd_data = {22'h000000, state_reg.thr[2]};
            ADDR_THR0 + 8'h0c: rd_data = {22'h000000, state_reg.thr[3]};
            ADDR_MON0:      rd_data = {22'h000000, state_reg.mon[0]};
            ADDR_MON0 + 8'h04: rd_data = {22'h000000, state_reg.mon[1]};
            ADDR_MON0 + 8'h08: rd_data = {22'h000000, state_reg.mon[2]};
            ADDR_MON0 + 8'h0c: rd_data = {22'h000000, state_reg.mon[3]};
            ADDR_METHOD: rd_data = {24'h000000, state_reg.method};
            ADDR_STATUS: rd_data = {19'h00000, state_reg.boot_done,
                                    state_reg.at_run, stop_bit,
                                    state_reg.heater_break_alarm};
            default:
            begin
                hit     = 1'b0;
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;

        // Bus answer
        state_next.rsp.pready  = rd_en || wr_en;
        state_next.rsp.pslverr = (rd_en || wr_en) && !hit;
        state_next.rsp.prdata  = rd_en ? rd_data : 32'h0000_0000;

        // Writes; reserved control bits are dropped
        if (wr_en)
        begin
            case (paddr_i)
                ADDR_CTRL12: state_next.ctrl12 = wdata16 & CTRL_MASK;
                ADDR_CTRL34: state_next.ctrl34 = wdata16 & CTRL_MASK;
                ADDR_THR0:         state_next.thr[0] = pwdata_i[9:0];
                ADDR_THR0 + 8'h04: state_next.thr[1] = pwdata_i[9:0];
                ADDR_THR0 + 8'h08: state_next.thr[2] = pwdata_i[9:0];
                ADDR_THR0 + 8'h0c: state_next.thr[3] = pwdata_i[9:0];
                ADDR_METHOD: state_next.method = pwdata_i[7:0];
                default:
                begin
                    state_next.method = state_reg.method;
                end
            endcase
        end

        // Millisecond enable
        state_next.tick = 1'b0;
        if (state_reg.tick_cnt == 18'(TICK_CYCLES - 1))
        begin
            state_next.tick_cnt = 18'h00000;
            state_next.tick     = 1'b1;
        end
        else
        begin
            state_next.tick_cnt = state_reg.tick_cnt + 18'h00001;
        end

        // Power-up hold of the ctrl_out and alarm outputs
        if (state_reg.tick && !state_reg.boot_done)
        begin
            if (state_reg.boot_ms == 12'(BOOT_HOLD_MS - 1))
            begin
                state_next.boot_done = 1'b1;
            end
            state_next.boot_ms = state_reg.boot_ms + 12'h001;
        end

        for (int l = 0; l < LOOPS; l++)
        begin
            state_next.mon[l] = current_sense_transformer_i[l];

            // Auto-tuning: stop wins over start
            if (at_stop_bit[l])
            begin
                state_next.at_run[l] = 1'b0;
            end
            else if (at_start_bit[l])
            begin
                state_next.at_run[l] = 1'b1;
            end

            // On-time, measured on the gated output actually driven
            if (!state_reg.out.ctrl_out[l])
            begin
                state_next.on_ms[l] = 8'h00;
            end
            else if (state_reg.tick && state_reg.on_ms[l] != 8'hff)
            begin
                state_next.on_ms[l] = state_reg.on_ms[l] + 8'h01;
            end

            // Latched break alarm per loop
            if (state_reg.thr[l] == THR_OFF)
            begin
                state_next.heater_break_alarm[l] = 1'b0;
            end
            else if (state_reg.thr[l] >= THR_FORCE)
            begin
                state_next.heater_break_alarm[l] = 1'b1;
            end
            else if (state_reg.method[l] == METH_TIME_PROP
                     && state_reg.boot_done
                     && state_reg.on_ms[l] > 8'(DETECT_MS)
                     && state_reg.mon[l] < state_reg.thr[l])
            begin
                state_next.heater_break_alarm[l] = 1'b1;
            end

            // Regulation never looks at the alarm
            state_next.out.ctrl_out[l] = state_reg.boot_done
                                         && !stop_bit[l]
                                         && ctrl_demand_i[l];
            state_next.out.alarm[l] = state_reg.boot_done
                                      && state_reg.heater_break_alarm[l];
        end

        state_next.out.at_run      = state_reg.at_run;
        state_next.out.save_req    = save_bit;
        state_next.out.pid_chg_req = pid_bit;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg        <= '0;
            state_reg.ctrl12 <= CTRL_RESET;
            state_reg.ctrl34 <= CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign apb_rsp_o = state_reg.rsp;
    assign loop_o    = state_reg.out;

endmodule

`default_nettype wire

// [verification/hbl_host.sv]
// APB master standing for the host CPU; one blocking transfer task.
// Assumes the slave answers with a one-cycle pready pulse.
`timescale 1ns/1ps
`default_nettype none

module hbl_host
    import hbl_pkg::*;
(
    input  wire hbl_apb_rsp_t rsp_i,
    input  wire logic         clk_i,
    output var  logic         psel_o,
    output var  logic         penable_o,
    output var  logic         pwrite_o,
    output var  logic [7:0]   paddr_o,
    output var  logic [31:0]  pwdata_o
);
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'hff;
        pwdata_o = 32'hffffffff;
    end

    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // Look between edges, where pready and prdata are settled
        do @(negedge clk_i); while (rsp_i.pready !== 1'b1);
        q = rsp_i.prdata;
        err = rsp_i.pslverr;
        // Release only after the edge that samples pready high
        @(posedge clk_i);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released lines must not keep the old value
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// [verification/hbl_top_asserts.sv]
// Port-level checker for the heater break block.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module hbl_top_asserts
    import hbl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [7:0]            paddr_i,
    input wire logic [31:0]           pwdata_i,
    input wire hbl_apb_rsp_t          apb_rsp_o,
    input wire logic [LOOPS-1:0]      ctrl_demand_i,
    input wire logic [LOOPS-1:0][9:0] current_sense_transformer_i,
    input wire hbl_loop_out_t         loop_o
);
    // Margin of one tick: the divider phase is not pinned down
    localparam int HOLD = (BOOT_HOLD_MS - 1) * TICK_CYCLES;
    logic [31:0] boot_cnt_reg;
    logic        wr_acc;
    assign wr_acc = psel_i && penable_i && pwrite_i;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            boot_cnt_reg <= 32'h0;
        else if (boot_cnt_reg < HOLD)
            boot_cnt_reg <= boot_cnt_reg + 32'h1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_access;
        psel_i && penable_i && !apb_rsp_o.pready;
    endsequence
    sequence s_wr_back;
        $past(wr_acc, 2) || $past(wr_acc, 3);
    endsequence

    ready_answer_a: assert property (s_access |=> apb_rsp_o.pready)
        else $error("pready late");
    ready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("pready too long");
    ready_cause_a: assert property
        (apb_rsp_o.pready |-> $past(psel_i) && $past(penable_i))
        else $error("pready without access");
    err_with_ready_a: assert property
        (apb_rsp_o.pslverr |-> apb_rsp_o.pready)
        else $error("pslverr alone");
    rdata_idle_a: assert property
        (!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0)
        else $error("prdata not idle");
    ctrl_demand_a: assert property
        ((loop_o.ctrl_out & ~$past(ctrl_demand_i)) == 4'h0)
        else $error("control out without demand");
    boot_hold_a: assert property
        (boot_cnt_reg < HOLD |-> loop_o.ctrl_out == 4'h0
            && loop_o.alarm == 4'h0)
        else $error("output during power-up hold");
    alarm_latch_a: assert property
        ((|($past(loop_o.alarm) & ~loop_o.alarm)) |-> s_wr_back)
        else $error("alarm dropped without write");
endmodule

bind hbl_top hbl_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .apb_rsp_o(apb_rsp_o),
    .ctrl_demand_i(ctrl_demand_i),
    .current_sense_transformer_i(current_sense_transformer_i),
    .loop_o(loop_o));
`default_nettype wire

// [verification/hbl_top_tb.sv]
// Self-checking bench: registers over APB, stop bits, alarm timing.
// Assumes hbl_host as bus master and a shortened ms tick.
`timescale 1ns/1ps
`default_nettype none

module hbl_top_tb
    import hbl_pkg::*;
;
    localparam int TK = 4;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    logic err;
    logic [LOOPS-1:0] dem = 4'h0;
    logic [LOOPS-1:0][9:0] cur = '0;
    hbl_apb_rsp_t rsp;
    hbl_loop_out_t lo;
    int n_fail = 0;
    int compares = 0;

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    hbl_host u_host (.clk_i(clk_i), .rsp_i(rsp), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));
    hbl_top #(.TICK_CYCLES(TK)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .apb_rsp_o(rsp),
        .ctrl_demand_i(dem), .current_sense_transformer_i(cur),
        .loop_o(lo));

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q, err);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic x);
        u_host.xfer(1'b0, a, 32'h0, q, err);
        chk("prdata", e, q);
        chk("pslverr", {31'h0, x}, {31'h0, err});
    endtask
    task automatic wait_ck(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        dem <= 4'hf;
        rd(ADDR_CTRL12, 32'h0, 1'b0);
        rd(ADDR_CTRL34, 32'h0, 1'b0);
        rd(8'h7c, 32'h0, 1'b1);
        chk("ctrl_out", 4'h0, lo.ctrl_out);
        wait_ck(BOOT_HOLD_MS * TK + 8);
        chk("ctrl_out", 4'hf, lo.ctrl_out);
        $display("boot done");
    endtask
    task automatic t_stop();
        wr(ADDR_CTRL12, 32'h0fe0);
        rd(ADDR_CTRL12, 32'h0040, 1'b0);
        wait_ck(2);
        chk("ctrl_out", 4'he, lo.ctrl_out);
        wr(ADDR_CTRL12, 32'h0010);
        wr(ADDR_CTRL34, 32'h0050);
        wait_ck(2);
        chk("ctrl_out", 4'h1, lo.ctrl_out);
        wr(ADDR_CTRL12, 32'ha004);
        wait_ck(3);
        chk("save_req", 4'h1, lo.save_req);
        chk("pid_chg_req", 4'h1, lo.pid_chg_req);
        chk("at_run", 4'h1, lo.at_run);
        wr(ADDR_CTRL12, 32'h000c);
        wait_ck(3);
        chk("at_run", 4'h0, lo.at_run);
        wr(ADDR_CTRL12, 32'h0);
        wr(ADDR_CTRL34, 32'h0);
        wait_ck(2);
        chk("ctrl_out", 4'hf, lo.ctrl_out);
        $display("stop done");
    endtask
    task automatic t_alarm();
        cur <= {10'd10, 10'd100, 10'd10, 10'd10};
        wr(ADDR_METHOD, 32'h84);
        wr(ADDR_THR0, 32'd20);
        wr(ADDR_THR0 + 8'h4, 32'd20);
        wr(ADDR_THR0 + 8'h8, 32'd500);
        wr(ADDR_THR0 + 8'hc, 32'd20);
        rd(ADDR_MON0, 32'd10, 1'b0);
        rd(ADDR_MON0 + 8'h8, 32'd100, 1'b0);
        wait_ck(210 * TK);
        chk("alarm", 4'h5, lo.alarm);
        chk("ctrl_out", 4'hf, lo.ctrl_out);
        cur <= {4{10'd100}};
        wait_ck(10);
        chk("alarm", 4'h5, lo.alarm);
        wr(ADDR_THR0, 32'h0);
        wait_ck(3);
        chk("alarm", 4'h4, lo.alarm);
        $display("alarm done");
    endtask
    task automatic t_ontime();
        dem <= 4'he;
        cur <= {10'd100, 10'd100, 10'd100, 10'd10};
        wr(ADDR_THR0, 32'd20);
        dem <= 4'hf;
        wait_ck(190 * TK);
        chk("alarm", 4'h4, lo.alarm);
        wait_ck(20 * TK);
        chk("alarm", 4'h5, lo.alarm);
        $display("ontime done");
    endtask

    initial
    begin
        #(30000 * 5);
        n_fail++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_boot();
        t_stop();
        t_alarm();
        t_ontime();
        final_report();
    end
endmodule
`default_nettype wire
